// *** rtl/crs_regset.sv ***
/*
 * CPU programmer-visible register set: two banks of data, address and
 * frame-base registers, static base, vector table base, program counter,
 * dual stack pointers and the status word, plus the fixed address map.
 * Assumes a single-cycle register port (no wait states) and an ALU that
 * reports each result with a one-cycle update strobe.
 *
 * // Summary of operation
 * // four 16-bit data registers; first two also split into bytes
 * // third:first and fourth:second data registers form 32-bit pairs
 * // two 16-bit address registers, pairable into one 32-bit register
 * // 16-bit frame base feeds frame-relative addressing
 * // 16-bit static base feeds static-base-relative addressing
 * // 20-bit base of the relocatable interrupt vector table
 * // 20-bit program counter holds next instruction address
 * // user and interrupt stack pointers, flag picks the active one
 * // status word is 11 bits wide
 * // carry flag takes ALU carry, borrow or shifted-out bit
 * // software keeps the debug flag at zero
 * // zero flag set when result is zero, else cleared
 * // sign flag set when result is negative, else cleared
 * // bank flag steers register accesses to bank 0 or bank 1
 * // overflow flag set on overflow, else cleared
 * // decoder spans the whole 1-Mbyte, 20-bit space
 * program ROM ends at 0ffff, mapped downward; addresses above it up to the top decode as unassigned
 * // fixed vector table sits at the top of program ROM
 * // data flash decoded at its fixed range
 * // RAM mapped upward from its base, 1 Kbyte ending at given top
 * // Peripheral_control_area fill the lowest addresses; unassigned ones are refused
 * // all registers clocked by CPU clock and reset to known values
 */
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module crs_regset (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // alu status
   input wire logic alu_upd,
   input wire logic alu_word,
   input wire logic [15:0] alu_res,
   input wire logic alu_cout,
   input wire logic alu_ovf,
   // instruction sequencing
   input wire logic pc_adv,
   input wire logic [2:0] pc_len,
   // relative addressing
   input wire crs_pkg::crs_ea_t ea_mode,
   input wire logic [15:0] ea_disp,
   output logic [15:0] ea_addr,
   // register views
   output logic [31:0] data_pair_low,
   output logic [31:0] data_pair_high,
   output logic [31:0] addr_pair,
   output logic [19:0] vec_base,
   output logic [19:0] prog_count,
   output logic [15:0] stack_ptr,
   output logic [10:0] status_flags,
   // address map
   input wire logic [19:0] mem_addr,
   input wire logic sfr_assigned,
   output logic hit_sfr,
   output logic hit_ram,
   output logic hit_dflash,
   output logic hit_rom,
   output logic hit_vect,
   output logic hit_none,
   output logic acc_deny
);
   import crs_pkg::*;

   typedef struct packed {
      logic [1:0][3:0][15:0] dat;
      logic [1:0][1:0][15:0] adr;
      logic [1:0][15:0] fb;
      logic [15:0] sb;
      logic [15:0] user_stack_pointer;
      logic [15:0] interrupt_stack_pointer;
      logic [19:0] vector_table_base;
      logic [19:0] pc;
      logic [FLG_W-1:0] processor_status;
      logic [31:0] rdata;
      logic [15:0] ea;
   } crs_state_t;

   crs_state_t s_d, s_q;
   logic bank;
   logic usel;
   logic wr_flg;
   logic [10:0] flg_w;
   logic [10:0] flg_n;
   logic [15:0] ea_base;

   ///////////////////////////////////////////////////////////////////////
   // bank and stack selection come from the registered word, so a status
   // write takes effect for accesses from the next cycle on
   assign bank = s_q.processor_status[FB_B];
   assign usel = s_q.processor_status[FB_U];
   assign wr_flg = reg_wr && (reg_addr == RI_FLG);
   assign flg_w = wr_flg ? reg_wdata[FLG_W-1:0] : s_q.processor_status;

   // software writes the debug bit as given; keeping it zero is its job
   crs_flag_unit u_flag (
      .flg_in(flg_w),
      .upd(alu_upd),
      .word(alu_word),
      .res(alu_res),
      .cout(alu_cout),
      .ovf(alu_ovf),
      .flg_out(flg_n)
   );

   // base for relative addressing; frame base and address registers come from the current bank, static base is unbanked
   always_comb begin
      unique case (ea_mode)
         CRS_EA_FB: ea_base = s_q.fb[bank];
         CRS_EA_SB: ea_base = s_q.sb;
         CRS_EA_A0: ea_base = s_q.adr[bank][0];
         CRS_EA_A1: ea_base = s_q.adr[bank][1];
      endcase
   end

   ///////////////////////////////////////////////////////////////////////
   // register port: writes land this edge, read data stand one cycle
   always_comb begin
      s_d = s_q;
      s_d.processor_status = flg_n;
      s_d.ea = ea_base + ea_disp;
      s_d.rdata = '0;
      // pc counts forward unless software reloads it this cycle
      if (pc_adv) begin
         s_d.pc = s_q.pc + {17'h00000, pc_len};
      end
      if (reg_wr) begin
         unique case (reg_addr)
            RI_DAT0: s_d.dat[bank][0] = reg_wdata[15:0];
            RI_DAT1: s_d.dat[bank][1] = reg_wdata[15:0];
            RI_DAT2: s_d.dat[bank][2] = reg_wdata[15:0];
            RI_DAT3: s_d.dat[bank][3] = reg_wdata[15:0];
            RI_ADR0: s_d.adr[bank][0] = reg_wdata[15:0];
            RI_ADR1: s_d.adr[bank][1] = reg_wdata[15:0];
            RI_FB: s_d.fb[bank] = reg_wdata[15:0];
            RI_SB: s_d.sb = reg_wdata[15:0];
            RI_VECTOR_TABLE_BASE: s_d.vector_table_base = reg_wdata[19:0];
            RI_PC: s_d.pc = reg_wdata[19:0];
            RI_USP: s_d.user_stack_pointer = reg_wdata[15:0];
            RI_ISP: s_d.interrupt_stack_pointer = reg_wdata[15:0];
            RI_D0H: s_d.dat[bank][0][15:8] = reg_wdata[7:0];
            RI_D0L: s_d.dat[bank][0][7:0] = reg_wdata[7:0];
            RI_D1H: s_d.dat[bank][1][15:8] = reg_wdata[7:0];
            RI_D1L: s_d.dat[bank][1][7:0] = reg_wdata[7:0];
            RI_PAIR_LO: begin
               s_d.dat[bank][2] = reg_wdata[31:16];
               s_d.dat[bank][0] = reg_wdata[15:0];
            end
            RI_PAIR_HI: begin
               s_d.dat[bank][3] = reg_wdata[31:16];
               s_d.dat[bank][1] = reg_wdata[15:0];
            end
            RI_APAIR: begin
               s_d.adr[bank][1] = reg_wdata[31:16];
               s_d.adr[bank][0] = reg_wdata[15:0];
            end
            RI_SP: begin
               // the active pointer alias follows the stack-select flag
               if (usel) begin
                  s_d.user_stack_pointer = reg_wdata[15:0];
               end else begin
                  s_d.interrupt_stack_pointer = reg_wdata[15:0];
               end
            end
            default: ; // status word handled above, unmapped ignored
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            RI_DAT0: s_d.rdata = {16'h0000, s_q.dat[bank][0]};
            RI_DAT1: s_d.rdata = {16'h0000, s_q.dat[bank][1]};
            RI_DAT2: s_d.rdata = {16'h0000, s_q.dat[bank][2]};
            RI_DAT3: s_d.rdata = {16'h0000, s_q.dat[bank][3]};
            RI_ADR0: s_d.rdata = {16'h0000, s_q.adr[bank][0]};
            RI_ADR1: s_d.rdata = {16'h0000, s_q.adr[bank][1]};
            RI_FB: s_d.rdata = {16'h0000, s_q.fb[bank]};
            RI_SB: s_d.rdata = {16'h0000, s_q.sb};
            RI_VECTOR_TABLE_BASE: s_d.rdata = {12'h000, s_q.vector_table_base};
            RI_PC: s_d.rdata = {12'h000, s_q.pc};
            RI_USP: s_d.rdata = {16'h0000, s_q.user_stack_pointer};
            RI_ISP: s_d.rdata = {16'h0000, s_q.interrupt_stack_pointer};
            RI_FLG: s_d.rdata = {21'h000000, s_q.processor_status};
            RI_D0H: s_d.rdata = {24'h000000, s_q.dat[bank][0][15:8]};
            RI_D0L: s_d.rdata = {24'h000000, s_q.dat[bank][0][7:0]};
            RI_D1H: s_d.rdata = {24'h000000, s_q.dat[bank][1][15:8]};
            RI_D1L: s_d.rdata = {24'h000000, s_q.dat[bank][1][7:0]};
            RI_PAIR_LO: s_d.rdata = {s_q.dat[bank][2], s_q.dat[bank][0]};
            RI_PAIR_HI: s_d.rdata = {s_q.dat[bank][3], s_q.dat[bank][1]};
            RI_APAIR: s_d.rdata = {s_q.adr[bank][1], s_q.adr[bank][0]};
            RI_SP: s_d.rdata = {16'h0000, usel ? s_q.user_stack_pointer : s_q.interrupt_stack_pointer};
            default: s_d.rdata = '0; // unmapped reads as zero
         endcase
      end
   end

   // whole state resets to constants on the cpu clock domain
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q.dat <= '0;
         s_q.adr <= '0;
         s_q.fb <= '0;
         s_q.sb <= R16_RST;
         s_q.user_stack_pointer <= R16_RST;
         s_q.interrupt_stack_pointer <= R16_RST;
         s_q.vector_table_base <= R20_RST;
         s_q.pc <= R20_RST;
         s_q.processor_status <= FLG_RST;
         s_q.rdata <= '0;
         s_q.ea <= R16_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // register views
   assign reg_rdata = s_q.rdata;
   assign ea_addr = s_q.ea;
   assign data_pair_low = {s_q.dat[bank][2], s_q.dat[bank][0]};
   assign data_pair_high = {s_q.dat[bank][3], s_q.dat[bank][1]};
   assign addr_pair = {s_q.adr[bank][1], s_q.adr[bank][0]};
   assign vec_base = s_q.vector_table_base;
   assign prog_count = s_q.pc;
   assign stack_ptr = usel ? s_q.user_stack_pointer : s_q.interrupt_stack_pointer;
   assign status_flags = s_q.processor_status;

   // fixed memory map
   crs_addr_decode u_dec (
      .mclk(mclk),
      .rstn(rstn),
      .addr(mem_addr),
      .sfr_assigned(sfr_assigned),
      .hit_sfr(hit_sfr),
      .hit_ram(hit_ram),
      .hit_dflash(hit_dflash),
      .hit_rom(hit_rom),
      .hit_vect(hit_vect),
      .hit_none(hit_none),
      .acc_deny(acc_deny)
   );

   ///////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence bank1_set_s;
      reg_wr && reg_addr == RI_FLG && reg_wdata[FB_B];
   endsequence
   sequence d0_write_s;
      reg_wr && reg_addr == RI_DAT0 && !alu_upd;
   endsequence

   byte_split_a: assert property (reg_wr && reg_addr == RI_D0H |=>
      s_q.dat[bank][0] == {$past(reg_wdata[7:0]),
      $past(s_q.dat[bank][0][7:0])})
      else $error("high byte write wrong");
   pair_read_a: assert property (reg_rd && reg_addr == RI_PAIR_HI |=>
      reg_rdata == $past(data_pair_high))
      else $error("data pair read wrong");
   addr_pair_a: assert property (reg_wr && reg_addr == RI_APAIR |=>
      s_q.adr[bank][0] == $past(reg_wdata[15:0]) &&
      s_q.adr[bank][1] == $past(reg_wdata[31:16]))
      else $error("address pair split wrong");
   fb_base_a: assert property (ea_mode == CRS_EA_FB |=>
      ea_addr == $past(s_q.fb[bank] + ea_disp))
      else $error("frame relative address wrong");
   sb_base_a: assert property (ea_mode == CRS_EA_SB |=>
      ea_addr == $past(s_q.sb + ea_disp))
      else $error("static base address wrong");
   pc_step_a: assert property (pc_adv && !(reg_wr && reg_addr == RI_PC) |=>
      prog_count == $past(prog_count) + {17'h00000, $past(pc_len)})
      else $error("program counter step wrong");
   sp_alias_a: assert property (reg_wr && reg_addr == RI_SP && !usel |=>
      s_q.interrupt_stack_pointer == $past(reg_wdata[15:0]) && s_q.user_stack_pointer == $past(s_q.user_stack_pointer))
      else $error("stack alias wrote wrong pointer");
   carry_zero_a: assert property (alu_upd && alu_word && alu_res == 16'h0000
      |=> status_flags[FB_Z] && status_flags[FB_C] == $past(alu_cout))
      else $error("carry or zero flag wrong");
   sign_ovf_a: assert property (alu_upd && !alu_word |=>
      status_flags[FB_S] == $past(alu_res[7]) &&
      status_flags[FB_O] == $past(alu_ovf))
      else $error("sign or overflow flag wrong");
   bank_steer_a: assert property ((bank1_set_s and !alu_upd) ##1 d0_write_s
      |=> s_q.dat[1][0] == $past(reg_wdata[15:0]) &&
      s_q.dat[0][0] == $past(s_q.dat[0][0]))
      else $error("bank steering wrong");
endmodule // crs_regset
`default_nettype wire

// *** shared/crs_pkg.sv ***
/*
 * Shared constants for the CPU register set: register port indices,
 * status-word bit positions, reset values and the fixed memory map.
 * Assumes a 20-bit address space and a word-indexed register port.
 */
package crs_pkg;
   // register port indices (one 32-bit word each, narrow data in low bits)
   localparam logic [4:0] RI_DAT0 = 5'h00;
   localparam logic [4:0] RI_DAT1 = 5'h01;
   localparam logic [4:0] RI_DAT2 = 5'h02;
   localparam logic [4:0] RI_DAT3 = 5'h03;
   localparam logic [4:0] RI_ADR0 = 5'h04;
   localparam logic [4:0] RI_ADR1 = 5'h05;
   localparam logic [4:0] RI_FB = 5'h06;
   localparam logic [4:0] RI_SB = 5'h07;
   localparam logic [4:0] RI_VECTOR_TABLE_BASE = 5'h08;
   localparam logic [4:0] RI_PC = 5'h09;
   localparam logic [4:0] RI_USP = 5'h0a;
   localparam logic [4:0] RI_ISP = 5'h0b;
   localparam logic [4:0] RI_FLG = 5'h0c;
   localparam logic [4:0] RI_D0H = 5'h0d;
   localparam logic [4:0] RI_D0L = 5'h0e;
   localparam logic [4:0] RI_D1H = 5'h0f;
   localparam logic [4:0] RI_D1L = 5'h10;
   localparam logic [4:0] RI_PAIR_LO = 5'h11;
   localparam logic [4:0] RI_PAIR_HI = 5'h12;
   localparam logic [4:0] RI_APAIR = 5'h13;
   localparam logic [4:0] RI_SP = 5'h14;
   // status word bit positions
   localparam int unsigned FLG_W = 11;
   localparam int unsigned FB_C = 0;
   localparam int unsigned FB_D = 1;
   localparam int unsigned FB_Z = 2;
   localparam int unsigned FB_S = 3;
   localparam int unsigned FB_B = 4;
   localparam int unsigned FB_O = 5;
   localparam int unsigned FB_I = 6;
   localparam int unsigned FB_U = 7;
   // reset values
   localparam logic [15:0] R16_RST = 16'h0000;
   localparam logic [19:0] R20_RST = 20'h00000;
   localparam logic [10:0] FLG_RST = 11'h000;
   // fixed memory map (20-bit, whole 1-Mbyte space)
   localparam logic [19:0] MAP_TOP = 20'hfffff;
   localparam logic [19:0] SFR_TOP = 20'h002ff;
   localparam logic [19:0] RAM_BASE = 20'h00400;
   localparam logic [19:0] RAM_TOP = 20'h007ff;
   localparam logic [19:0] DFL_BASE = 20'h02400;
   localparam logic [19:0] DFL_TOP = 20'h02bff;
   localparam logic [19:0] ROM_BASE = 20'h0c000;
   localparam logic [19:0] ROM_TOP = 20'h0ffff;
   localparam logic [19:0] VEC_BASE = 20'h0ffdc;
   // base selection for relative addressing
   typedef enum logic [1:0] {
      CRS_EA_FB,
      CRS_EA_SB,
      CRS_EA_A0,
      CRS_EA_A1
   } crs_ea_t;
endpackage

// *** rtl/crs_flag_unit.sv ***
/*
 * Status-word update from one ALU result; purely combinational.
 * Assumes the caller registers the result and supplies the base word.
 */
`timescale 1ns/1ps
`default_nettype none
module crs_flag_unit (
   // base status word
   input wire logic [10:0] flg_in,
   // alu result
   input wire logic upd,
   input wire logic word,
   input wire logic [15:0] res,
   input wire logic cout,
   input wire logic ovf,
   // updated status word
   output logic [10:0] flg_out
);
   import crs_pkg::*;

   // alu fields win over a same-cycle software write of the word
   always_comb begin
      flg_out = flg_in;
      if (upd) begin
         flg_out[FB_C] = cout;
         flg_out[FB_Z] = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
         flg_out[FB_S] = word ? res[15] : res[7];
         flg_out[FB_O] = ovf;
      end
   end
endmodule // crs_flag_unit
`default_nettype wire

// *** rtl/crs_addr_decode.sv ***
/*
 * Registered decode of a 20-bit address into the fixed regions.
 * Assumes the peripheral side reports whether an SFR slot is assigned.
 */
`timescale 1ns/1ps
`default_nettype none
module crs_addr_decode (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // address in
   input wire logic [19:0] addr,
   input wire logic sfr_assigned,
   // region hits, one cycle after the address
   output logic hit_sfr,
   output logic hit_ram,
   output logic hit_dflash,
   output logic hit_rom,
   output logic hit_vect,
   output logic hit_none,
   output logic acc_deny
);
   import crs_pkg::*;

   typedef struct packed {
      logic sfr, ram, dfl, rom, vec, none, deny;
   } crs_dec_t;
   crs_dec_t s_d, s_q;

   ///////////////////////////////////////////////////////////////////////
   // compares; 20 bits cover the whole space so nothing aliases
   always_comb begin
      s_d.sfr = (addr <= SFR_TOP);
      s_d.ram = (addr >= RAM_BASE) && (addr <= RAM_TOP);
      s_d.dfl = (addr >= DFL_BASE) && (addr <= DFL_TOP);
      s_d.rom = (addr >= ROM_BASE) && (addr <= ROM_TOP);
      s_d.vec = (addr >= VEC_BASE) && (addr <= ROM_TOP);
      s_d.none = !(s_d.sfr || s_d.ram || s_d.dfl || s_d.rom);
      s_d.deny = s_d.sfr && !sfr_assigned;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit_sfr = s_q.sfr;
   assign hit_ram = s_q.ram;
   assign hit_dflash = s_q.dfl;
   assign hit_rom = s_q.rom;
   assign hit_vect = s_q.vec;
   assign hit_none = s_q.none;
   assign acc_deny = s_q.deny;

   ///////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   rom_window_a: assert property ($past(addr) == 20'h0c000 |-> hit_rom)
      else $error("rom base not decoded");
   vect_inside_rom_a: assert property (hit_vect |-> hit_rom)
      else $error("vector hit outside rom");
   dflash_edge_a: assert property (addr == 20'h02c00 |=> !hit_dflash)
      else $error("data flash past its top");
   ram_edge_a: assert property (addr == 20'h007ff |=> hit_ram && !hit_none)
      else $error("ram top not decoded");
   sfr_deny_a: assert property (addr == 20'h00300 |=> !hit_sfr && !acc_deny)
      else $error("sfr range too wide");
endmodule // crs_addr_decode
`default_nettype wire

// *** dv/crs_regset_tb_top.sv ***
/*
 * Self-checking bench for the CPU register set: register port, byte and
 * pair views, relative bases, stack select, status word and memory map.
 * Assumes crs_pkg is compiled first and crs_regset is the design top.
 */
`timescale 1ns/1ps
`default_nettype none
module crs_regset_tb_top;
   import crs_pkg::*;
   logic mclk, rstn, reg_wr, reg_rd, alu_upd, alu_word, alu_cout, alu_ovf;
   logic pc_adv, sfr_assigned, hit_sfr, hit_ram, hit_dflash, hit_rom;
   logic hit_vect, hit_none, acc_deny;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, data_pair_low, data_pair_high, addr_pair;
   logic [15:0] alu_res, ea_disp, ea_addr, stack_ptr;
   logic [2:0] pc_len;
   crs_ea_t ea_mode;
   logic [19:0] vec_base, prog_count, mem_addr;
   logic [10:0] status_flags;
   int fails = 0;
   int comparisons = 0;
   // map probe table: address, expected {sfr,ram,dfl,rom,vec,none,deny}
   logic [19:0] map_adr [20] = '{20'h00000, 20'h002ff, 20'h00300, 20'h003ff,
      20'h00400, 20'h007ff, 20'h00800, 20'h023ff, 20'h02400, 20'h02bff,
      20'h02c00, 20'h0bfff, 20'h0c000, 20'h0ffdb, 20'h0ffdc, 20'h0ffff,
      20'h10000, 20'hfffff, 20'h00100, 20'h00400};
   logic [6:0] map_exp [20] = '{7'h40, 7'h40, 7'h02, 7'h02, 7'h20, 7'h20,
      7'h02, 7'h02, 7'h10, 7'h10, 7'h02, 7'h02, 7'h08, 7'h08, 7'h0c, 7'h0c,
      7'h02, 7'h02, 7'h41, 7'h20};
   logic [19:0] map_sas = 20'h3ffff; // last two probes: slot not assigned

   crs_regset DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .alu_upd(alu_upd), .alu_word(alu_word),
      .alu_res(alu_res), .alu_cout(alu_cout), .alu_ovf(alu_ovf),
      .pc_adv(pc_adv), .pc_len(pc_len), .ea_mode(ea_mode),
      .ea_disp(ea_disp), .ea_addr(ea_addr), .data_pair_low(data_pair_low),
      .data_pair_high(data_pair_high), .addr_pair(addr_pair),
      .vec_base(vec_base), .prog_count(prog_count), .stack_ptr(stack_ptr),
      .status_flags(status_flags), .mem_addr(mem_addr),
      .sfr_assigned(sfr_assigned), .hit_sfr(hit_sfr), .hit_ram(hit_ram),
      .hit_dflash(hit_dflash), .hit_rom(hit_rom), .hit_vect(hit_vect),
      .hit_none(hit_none), .acc_deny(acc_deny));

   ////////////////////////////////////////////////////////////////////////
   // clock, compare and bus tasks
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk_val(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_hits(input logic [19:0] a, input logic [6:0] exp);
      logic [6:0] got;
      got = {hit_sfr, hit_ram, hit_dflash, hit_rom, hit_vect, hit_none,
             acc_deny};
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH hits at %h expected %b seen %b", a, exp, got);
      end
   endtask

   // one-cycle write strobe; one idle cycle follows before the next
   task automatic wr(input logic [4:0] idx, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= idx;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd_chk(input string what, input logic [4:0] idx,
                         input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= idx;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk_val(what, exp, reg_rdata);
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_views();
      wr(RI_DAT0, 32'hffff0000);
      wr(RI_D0H, 32'hffffff12);
      wr(RI_D0L, 32'hffffff34);
      wr(RI_D1H, 32'h00000056);
      wr(RI_D1L, 32'h00000078);
      wr(RI_DAT2, 32'h5555beef);
      wr(RI_DAT3, 32'h0000cafe);
      rd_chk("data0", RI_DAT0, 32'h00001234);
      rd_chk("data0 high", RI_D0H, 32'h00000012);
      rd_chk("data1 low", RI_D1L, 32'h00000078);
      rd_chk("pair low", RI_PAIR_LO, 32'hbeef1234);
      rd_chk("pair high", RI_PAIR_HI, 32'hcafe5678);
      chk_val("pair low view", 32'hbeef1234, data_pair_low);
      chk_val("pair high view", 32'hcafe5678, data_pair_high);
      wr(RI_PAIR_LO, 32'h9abcdef0);
      rd_chk("data2 via pair", RI_DAT2, 32'h00009abc);
      wr(RI_ADR0, 32'hffff1111);
      wr(RI_ADR1, 32'h00002222);
      #1;
      chk_val("addr pair view", 32'h22221111, addr_pair);
      wr(RI_APAIR, 32'h33334444);
      rd_chk("addr0 via pair", RI_ADR0, 32'h00004444);
   endtask

   task automatic t_bases();
      logic [15:0] base [4] = '{16'h1000, 16'h2000, 16'h4444, 16'h3333};
      logic [15:0] disp [4] = '{16'h0004, 16'hfff0, 16'h8000, 16'hffff};
      wr(RI_FB, 32'h00001000);
      wr(RI_SB, 32'h00002000);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         ea_mode <= crs_ea_t'(i);
         ea_disp <= disp[i];
         @(posedge mclk);
         #1;
         chk_val("relative addr", {16'h0, base[i] + disp[i]}, {16'h0, ea_addr});
      end
   endtask

   task automatic t_vec_pc();
      wr(RI_VECTOR_TABLE_BASE, 32'h12345678);
      rd_chk("vector base", RI_VECTOR_TABLE_BASE, 32'h00045678);
      chk_val("vector view", 32'h00045678, {12'h0, vec_base});
      wr(RI_PC, 32'h000ffffe);
      @(posedge mclk);
      pc_adv <= 1'b1;
      pc_len <= 3'h3;
      @(posedge mclk);
      pc_adv <= 1'b0;
      #1;
      chk_val("count wrap", 32'h00000001, {12'h0, prog_count});
   endtask

   task automatic t_stack();
      wr(RI_USP, 32'h00001111);
      wr(RI_ISP, 32'hffff2222);
      #1;
      chk_val("sp isp", 32'h00002222, {16'h0, stack_ptr});
      wr(RI_FLG, 32'h00000080);
      rd_chk("sp alias usp", RI_SP, 32'h00001111);
      chk_val("sp usp", 32'h00001111, {16'h0, stack_ptr});
      wr(RI_SP, 32'h00003333);
      rd_chk("sp alias to usp", RI_USP, 32'h00003333);
      // every bit but the debug flag, which software must leave at zero
      wr(RI_FLG, 32'hfffffffd);
      rd_chk("status width", RI_FLG, 32'h000007fd);
      wr(RI_FLG, 32'h00000000);
      wr(RI_SP, 32'h00004444);
      rd_chk("sp alias to isp", RI_ISP, 32'h00004444);
   endtask

   task automatic t_alu();
      logic w [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      logic [15:0] r [6] = '{16'h0000, 16'h8000, 16'h0100, 16'h0080,
                             16'h0080, 16'h7f01};
      logic [10:0] e;
      wr(RI_FLG, 32'h00000090);
      for (int i = 0; i < 6; i++) begin
         e = 11'h090;
         e[FB_C] = i[0];
         e[FB_O] = i[1];
         e[FB_Z] = w[i] ? (r[i] == 16'h0) : (r[i][7:0] == 8'h0);
         e[FB_S] = w[i] ? r[i][15] : r[i][7];
         @(posedge mclk);
         alu_upd <= 1'b1;
         alu_word <= w[i];
         alu_res <= r[i];
         alu_cout <= i[0];
         alu_ovf <= i[1];
         @(posedge mclk);
         alu_upd <= 1'b0;
         #1;
         chk_val("alu flags", {21'h0, e}, {21'h0, status_flags});
      end
      wr(RI_FLG, 32'h00000000);
   endtask

   // banked copy must survive while the other bank is written
   task automatic t_bank();
      wr(RI_DAT0, 32'h0000aaaa);
      // back to back: the bank switch must steer the very next write
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= RI_FLG;
      reg_wdata <= 32'h00000010;
      @(posedge mclk);
      reg_addr <= RI_DAT0;
      reg_wdata <= 32'h00005555;
      @(posedge mclk);
      reg_wr <= 1'b0;
      rd_chk("bank1 data0", RI_DAT0, 32'h00005555);
      wr(RI_FLG, 32'h00000000);
      rd_chk("bank0 data0", RI_DAT0, 32'h0000aaaa);
   endtask

   task automatic t_map();
      for (int i = 0; i < 20; i++) begin
         @(posedge mclk);
         mem_addr <= map_adr[i];
         sfr_assigned <= map_sas[i];
         @(posedge mclk);
         #1;
         chk_hits(map_adr[i], map_exp[i]);
      end
   endtask

   task automatic t_reset_vals();
      rd_chk("reset data0", RI_DAT0, 32'h0);
      rd_chk("reset isp", RI_ISP, 32'h0);
      chk_val("reset count", 32'h0, {12'h0, prog_count});
      chk_val("reset status", 32'h0, {21'h0, status_flags});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      {reg_wr, reg_rd, alu_upd, alu_word, alu_cout, alu_ovf, pc_adv} = '0;
      reg_addr = 5'h00;
      reg_wdata = 32'h0;
      alu_res = 16'h0;
      pc_len = 3'h0;
      ea_mode = CRS_EA_FB;
      ea_disp = 16'h0;
      mem_addr = 20'h0;
      sfr_assigned = 1'b1;
      rstn = 1'b0;
      do_reset();
      t_reset_vals();
      t_views();
      t_bases();
      t_vec_pc();
      t_stack();
      t_alu();
      t_bank();
      t_map();
      wr(5'h1f, 32'hdeadbeef);
      rd_chk("unmapped index", 5'h1f, 32'h0);
      wr(RI_DAT0, 32'h00001234);
      do_reset();
      t_reset_vals();
      give_verdict();
   end

   // whole run is under two hundred cycles; far longer means a hang
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
endmodule // crs_regset_tb_top
`default_nettype wire
